// ### include/virt_exc_pkg.sv
// constants, types and cause-code helpers for the virtualization exception cause coder
package virt_exc_pkg;
	localparam int XLEN = 32;
	localparam int PID_W = 3;
	localparam int FCH_W = 4;
	localparam int ECH_W = 11;
	localparam int PID_LSB = 16;
	localparam int FCONST_LSB = 8;
	localparam int ECONST_LSB = 12;
	localparam logic [7:0] BG_FAST_CONST = 8'hD8;
	localparam logic [3:0] BG_ORD_CONST = 4'hD;
	localparam logic [15:0] SE_FETCH_BUS = 16'h0011;
	localparam logic [15:0] SE_FETCH_SAFE = 16'h0013;
	localparam logic [15:0] SE_BANK_SAVE = 16'h001C;
	localparam logic [15:0] SE_BANK_RESTORE = 16'h001D;
	localparam logic [7:0] MP_BASE_GUEST = 8'h90;
	localparam logic [7:0] MP_BASE_HOST = 8'h98;
	localparam logic [7:0] MP_OFS_FETCH = 8'h00;
	localparam logic [7:0] MP_OFS_OPERAND = 8'h01;
	localparam logic [7:0] MP_OFS_TABLE = 8'h05;

	typedef enum logic [1:0] {
		ACC_FETCH = 2'b00,
		ACC_OPERAND = 2'b01,
		ACC_TABLE = 2'b10
	} access_e;

	typedef enum logic [3:0] {
		EV_NONE = 4'b0000,
		EV_BANK_SAVE = 4'b0001,
		EV_FETCH_BUS = 4'b0010,
		EV_FETCH_SAFE = 4'b0011,
		EV_BANK_RESTORE = 4'b0100,
		EV_MPU = 4'b0101,
		EV_HOST_NMI = 4'b0110,
		EV_HOST_FAST = 4'b0111,
		EV_HOST_ORD = 4'b1000,
		EV_BG_FAST = 4'b1001,
		EV_BG_ORD = 4'b1010,
		EV_GUEST_FAST = 4'b1011,
		EV_GUEST_ORD = 4'b1100
	} event_e;

	function automatic logic [XLEN-1:0] bg_fast_code(input logic [PID_W-1:0] pid,
		input logic [FCH_W-1:0] ch);
		logic [XLEN-1:0] c;
		c = '0;
		c[PID_LSB +: PID_W] = pid;
		c[FCONST_LSB +: 8] = BG_FAST_CONST;
		c[FCH_W-1:0] = ch;
		return c;
	endfunction

	function automatic logic [XLEN-1:0] bg_ord_code(input logic [PID_W-1:0] pid,
		input logic [ECH_W-1:0] ch);
		logic [XLEN-1:0] c;
		c = '0;
		c[PID_LSB +: PID_W] = pid;
		c[ECONST_LSB +: 4] = BG_ORD_CONST;
		c[ECH_W-1:0] = ch;
		return c;
	endfunction

	function automatic logic [XLEN-1:0] low_code(input logic [15:0] lo);
		return {16'h0000, lo};
	endfunction
endpackage

// ### rtl/mpu_cause_coder.sv
// protection verdict and cause code from host and guest entry results
`timescale 1ns/1ns
module mpu_cause_coder (
	// state and access
	input wire logic guest_mode_i,
	input wire virt_exc_pkg::access_e access_kind_i,
	// combined entry results
	input wire logic host_permit_i,
	input wire logic guest_permit_i,
	// verdict
	output logic violation_o,
	output logic [7:0] code_o
);
	import virt_exc_pkg::*;

	logic host_ok;
	logic guest_ok;
	logic [7:0] ofs;

	// host mode sees host entries as denying and guest entries as permitting
	assign host_ok = guest_mode_i ? host_permit_i : 1'b0;
	assign guest_ok = guest_mode_i ? guest_permit_i : 1'b1;
	// in host mode only the host entries decide whether the access is refused
	assign violation_o = guest_mode_i ? !(host_permit_i && guest_permit_i)
		: !host_permit_i;

	always_comb begin
		case (access_kind_i)
			ACC_OPERAND: ofs = MP_OFS_OPERAND;
			ACC_TABLE: ofs = MP_OFS_TABLE;
			default: ofs = MP_OFS_FETCH;
		endcase
	end

	// only host-deny with guest-permit selects the upper code group
	assign code_o = (!host_ok && guest_ok) ? (MP_BASE_HOST | ofs)
		: (MP_BASE_GUEST | ofs);
endmodule

// ### rtl/virt_exception_cause_coder.sv
// exception selection, cause coding and fatal-level save registers
`timescale 1ns/1ns
module virt_exception_cause_coder (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// cpu state
	input wire logic guest_mode_i,
	input wire logic [virt_exc_pkg::PID_W-1:0] current_partition_id_i,
	input wire logic [virt_exc_pkg::XLEN-1:0] pc_i,
	input wire logic [virt_exc_pkg::XLEN-1:0] fetch_pc_i,
	input wire logic [virt_exc_pkg::XLEN-1:0] host_status_word_i,
	input wire logic [virt_exc_pkg::XLEN-1:0] guest_status_word_i,
	input wire logic exc_to_guest_i,
	// interrupt controller
	input wire logic host_nonmaskable_irq_i,
	input wire logic host_fast_irq_i,
	input wire logic host_ordinary_irq_i,
	input wire logic guest_fast_irq_i,
	input wire logic guest_ordinary_irq_i,
	input wire logic background_fast_irq_i,
	input wire logic background_ordinary_irq_i,
	input wire logic [virt_exc_pkg::PID_W-1:0] irq_partition_i,
	input wire logic [virt_exc_pkg::FCH_W-1:0] fast_channel_i,
	input wire logic [virt_exc_pkg::ECH_W-1:0] ordinary_channel_i,
	// internal error sources
	input wire logic bank_save_error_i,
	input wire logic bank_restore_error_i,
	input wire logic fetch_bus_error_i,
	input wire logic fetch_safety_error_i,
	input wire logic fetch_from_icache_i,
	// protection check
	input wire logic mpu_check_i,
	input wire virt_exc_pkg::access_e access_kind_i,
	input wire logic host_permit_i,
	input wire logic guest_permit_i,
	input wire logic table_irq_access_i,
	// acknowledges
	output logic host_irq_ack_o,
	output logic guest_irq_ack_o,
	// taken exception
	output logic exception_taken_o,
	output logic [virt_exc_pkg::XLEN-1:0] exception_cause_o,
	output logic handle_in_host_o,
	output logic switch_to_host_o,
	output logic ordinary_level_o,
	output logic terminating_o,
	output logic icache_miss_o,
	// save registers
	output logic [virt_exc_pkg::XLEN-1:0] host_irq_cause_reg_o,
	output logic [virt_exc_pkg::XLEN-1:0] host_fatal_pc_save_o,
	output logic [virt_exc_pkg::XLEN-1:0] host_fatal_status_save_o,
	output logic [virt_exc_pkg::XLEN-1:0] host_fatal_cause_o,
	output logic [virt_exc_pkg::XLEN-1:0] guest_fatal_pc_save_o,
	output logic [virt_exc_pkg::XLEN-1:0] guest_fatal_status_save_o,
	output logic [virt_exc_pkg::XLEN-1:0] guest_fatal_cause_o
);
	import virt_exc_pkg::*;

	logic mpu_violation;
	logic [7:0] mpu_code;
	logic guest_match;
	logic fetch_safe_sys;
	logic to_guest;
	logic is_fatal;
	logic is_fetch;
	logic in_guest;
	event_e ev;
	logic [XLEN-1:0] nxt_cause;
	logic [XLEN-1:0] fatal_pc;
	logic [XLEN-1:0] fatal_status;

	logic taken_ff;
	logic [XLEN-1:0] cause_ff;
	logic in_host_ff;
	logic switch_ff;
	logic ord_level_ff;
	logic term_ff;
	logic icache_miss_ff;
	logic [XLEN-1:0] host_irq_cause_ff;
	logic [XLEN-1:0] host_fpc_ff;
	logic [XLEN-1:0] host_fpsw_ff;
	logic [XLEN-1:0] host_fcause_ff;
	logic [XLEN-1:0] guest_fpc_ff;
	logic [XLEN-1:0] guest_fpsw_ff;
	logic [XLEN-1:0] guest_fcause_ff;

	mpu_cause_coder u_mpu (
		.guest_mode_i(guest_mode_i),
		.access_kind_i(access_kind_i),
		.host_permit_i(host_permit_i),
		.guest_permit_i(guest_permit_i),
		.violation_o(mpu_violation),
		.code_o(mpu_code)
	);

	// partition of the request must be the one now running
	assign guest_match = guest_mode_i && (irq_partition_i == current_partition_id_i);
	// cache-sourced safety errors become a refill instead
	assign fetch_safe_sys = fetch_safety_error_i && !fetch_from_icache_i;
	assign to_guest = exc_to_guest_i && guest_mode_i;

	// fixed selection order; only internal causes feed the system error path
	always_comb begin
		ev = EV_NONE;
		if (bank_save_error_i) begin
			ev = EV_BANK_SAVE;
		end else if (fetch_bus_error_i) begin
			ev = EV_FETCH_BUS;
		end else if (fetch_safe_sys) begin
			ev = EV_FETCH_SAFE;
		end else if (bank_restore_error_i) begin
			ev = EV_BANK_RESTORE;
		end else if (mpu_check_i && mpu_violation) begin
			ev = EV_MPU;
		end else if (host_nonmaskable_irq_i) begin
			ev = EV_HOST_NMI;
		end else if (host_fast_irq_i) begin
			ev = EV_HOST_FAST;
		end else if (host_ordinary_irq_i) begin
			ev = EV_HOST_ORD;
		end else if (guest_mode_i && background_fast_irq_i) begin
			ev = EV_BG_FAST;
		end else if (guest_mode_i && background_ordinary_irq_i) begin
			ev = EV_BG_ORD;
		end else if (guest_match && guest_fast_irq_i) begin
			ev = EV_GUEST_FAST;
		end else if (guest_match && guest_ordinary_irq_i) begin
			ev = EV_GUEST_ORD;
		end
	end

	// background requests get no acceptance answer
	assign host_irq_ack_o = (ev == EV_HOST_NMI) || (ev == EV_HOST_FAST) || (ev == EV_HOST_ORD);
	assign guest_irq_ack_o = (ev == EV_GUEST_FAST) || (ev == EV_GUEST_ORD);

	assign is_fetch = (ev == EV_FETCH_BUS) || (ev == EV_FETCH_SAFE);
	assign is_fatal = (ev == EV_BANK_SAVE) || (ev == EV_BANK_RESTORE) || is_fetch
		|| (ev == EV_MPU);
	// handler placement: guest irqs and routed fatal causes stay in guest
	assign in_guest = guest_irq_ack_o || (is_fatal && to_guest);

	always_comb begin
		case (ev)
			EV_BANK_SAVE: nxt_cause = low_code(SE_BANK_SAVE);
			EV_BANK_RESTORE: nxt_cause = low_code(SE_BANK_RESTORE);
			EV_FETCH_BUS: nxt_cause = low_code(SE_FETCH_BUS);
			EV_FETCH_SAFE: nxt_cause = low_code(SE_FETCH_SAFE);
			EV_MPU: nxt_cause = {24'h000000, mpu_code};
			EV_BG_FAST: nxt_cause = bg_fast_code(irq_partition_i, fast_channel_i);
			EV_BG_ORD: nxt_cause = bg_ord_code(irq_partition_i, ordinary_channel_i);
			default: nxt_cause = '0;
		endcase
	end

	// fetch faults save the fetched PC, others the interrupted or failing one
	assign fatal_pc = is_fetch ? fetch_pc_i : pc_i;
	assign fatal_status = to_guest ? guest_status_word_i : host_status_word_i;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			taken_ff <= 1'b0;
			cause_ff <= '0;
		end else begin
			taken_ff <= (ev != EV_NONE);
			cause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_host_ff <= 1'b0;
			switch_ff <= 1'b0;
		end else begin
			in_host_ff <= (ev != EV_NONE) && !in_guest;
			switch_ff <= (ev != EV_NONE) && !in_guest && guest_mode_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ord_level_ff <= 1'b0;
			term_ff <= 1'b0;
			icache_miss_ff <= 1'b0;
		end else begin
			ord_level_ff <= (ev == EV_HOST_ORD) || (ev == EV_GUEST_ORD)
				|| (ev == EV_BG_FAST) || (ev == EV_BG_ORD);
			term_ff <= (ev == EV_BANK_SAVE)
				|| ((ev == EV_MPU) && table_irq_access_i);
			icache_miss_ff <= fetch_safety_error_i && fetch_from_icache_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_irq_cause_ff <= '0;
		end else if ((ev == EV_BG_FAST) || (ev == EV_BG_ORD)) begin
			host_irq_cause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_fpc_ff <= '0;
			host_fpsw_ff <= '0;
			host_fcause_ff <= '0;
		end else if (is_fatal && !to_guest) begin
			host_fpc_ff <= fatal_pc;
			host_fpsw_ff <= fatal_status;
			host_fcause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			guest_fpc_ff <= '0;
			guest_fpsw_ff <= '0;
			guest_fcause_ff <= '0;
		end else if (is_fatal && to_guest) begin
			guest_fpc_ff <= fatal_pc;
			guest_fpsw_ff <= fatal_status;
			guest_fcause_ff <= nxt_cause;
		end
	end

	assign exception_taken_o = taken_ff;
	assign exception_cause_o = cause_ff;
	assign handle_in_host_o = in_host_ff;
	assign switch_to_host_o = switch_ff;
	assign ordinary_level_o = ord_level_ff;
	assign terminating_o = term_ff;
	assign icache_miss_o = icache_miss_ff;
	assign host_irq_cause_reg_o = host_irq_cause_ff;
	assign host_fatal_pc_save_o = host_fpc_ff;
	assign host_fatal_status_save_o = host_fpsw_ff;
	assign host_fatal_cause_o = host_fcause_ff;
	assign guest_fatal_pc_save_o = guest_fpc_ff;
	assign guest_fatal_status_save_o = guest_fpsw_ff;
	assign guest_fatal_cause_o = guest_fcause_ff;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence bg_fast_take;
		ev == EV_BG_FAST;
	endsequence

	sequence bg_ord_take;
		ev == EV_BG_ORD;
	endsequence

	sequence host_switch_seen;
		switch_to_host_o && handle_in_host_o && ordinary_level_o;
	endsequence

	host_irq_mode_a: assert property (
		host_irq_ack_o |=> exception_taken_o && handle_in_host_o && !ordinary_level_o
			|| ordinary_level_o && $past(host_ordinary_irq_i))
		else $error("host interrupt not handled in host mode");

	guest_ack_match_a: assert property (
		guest_irq_ack_o |-> guest_mode_i && irq_partition_i == current_partition_id_i)
		else $error("guest interrupt taken with wrong mode or partition");

	bg_switch_a: assert property (
		(bg_fast_take or bg_ord_take) |=> host_switch_seen)
		else $error("background interrupt did not switch to host");

	bg_fast_code_a: assert property (
		bg_fast_take |=> host_irq_cause_reg_o
			== bg_fast_code($past(irq_partition_i), $past(fast_channel_i)))
		else $error("fast background cause code wrong");

	bg_ord_code_a: assert property (
		bg_ord_take |=> host_irq_cause_reg_o
			== bg_ord_code($past(irq_partition_i), $past(ordinary_channel_i)))
		else $error("ordinary background cause code wrong");

	bg_pad_zero_a: assert property (
		(bg_fast_take or bg_ord_take) |=> host_irq_cause_reg_o[XLEN-1:PID_LSB+PID_W] == '0)
		else $error("background cause upper bits not zero");

	bank_save_a: assert property (
		ev == EV_BANK_SAVE && !to_guest |=> terminating_o
			&& host_fatal_cause_o == low_code(SE_BANK_SAVE)
			&& host_fatal_pc_save_o == $past(pc_i)
			&& host_fatal_status_save_o == $past(host_status_word_i))
		else $error("bank save error not saved correctly");

	bank_restore_a: assert property (
		ev == EV_BANK_RESTORE |=> !terminating_o
			&& exception_cause_o == low_code(SE_BANK_RESTORE))
		else $error("bank restore error wrong cause or type");

	fetch_bus_a: assert property (
		fetch_bus_error_i && !bank_save_error_i && !to_guest |=> !terminating_o
			&& exception_cause_o == low_code(SE_FETCH_BUS)
			&& host_fatal_pc_save_o == $past(fetch_pc_i))
		else $error("fetch bus error not coded or saved");

	fetch_safe_a: assert property (
		ev == EV_FETCH_SAFE |=> exception_cause_o == low_code(SE_FETCH_SAFE))
		else $error("fetch safety error code wrong");

	fatal_upper_a: assert property (
		is_fatal && !to_guest |=> host_fatal_cause_o[XLEN-1:16] == '0)
		else $error("fatal cause upper half not zero");

	icache_miss_a: assert property (
		fetch_safety_error_i && fetch_from_icache_i |-> ev != EV_FETCH_SAFE ##1 icache_miss_o)
		else $error("cache safety error raised a system error");

	mpu_gate_a: assert property (
		ev == EV_MPU |-> mpu_check_i && mpu_violation)
		else $error("protection exception outside check point");

	table_term_a: assert property (
		ev == EV_MPU && table_irq_access_i |=> terminating_o && exception_taken_o)
		else $error("table protection fault not terminating");

	mdp_host_save_a: assert property (
		ev == EV_MPU && !to_guest |=> host_fatal_pc_save_o == $past(pc_i)
			&& host_fatal_status_save_o == $past(host_status_word_i))
		else $error("host fatal save wrong");

	mdp_guest_save_a: assert property (
		ev == EV_MPU && to_guest |=> guest_fatal_pc_save_o == $past(pc_i)
			&& guest_fatal_status_save_o == $past(guest_status_word_i))
		else $error("guest fatal save wrong");

	guest_deny_a: assert property (
		ev == EV_MPU && guest_mode_i && host_permit_i && access_kind_i == ACC_FETCH
			|=> exception_cause_o == {24'h000000, MP_BASE_GUEST | MP_OFS_FETCH})
		else $error("guest deny fetch code wrong");

	host_deny_a: assert property (
		ev == EV_MPU && !guest_mode_i && access_kind_i == ACC_OPERAND
			|=> exception_cause_o == {24'h000000, MP_BASE_HOST | MP_OFS_OPERAND})
		else $error("host mode operand code wrong");

	permit_none_a: assert property (
		(guest_mode_i ? host_permit_i && guest_permit_i : host_permit_i) |-> ev != EV_MPU)
		else $error("protection exception on permitted access");
endmodule

// ### test/irq_ctrl_model.sv
// behavioural interrupt controller that presents one pending guest-class cause
`timescale 1ns/1ns
module irq_ctrl_model
	import virt_exc_pkg::*;
(
	// pending cause
	input wire logic req_i,
	input wire logic fast_i,
	input wire logic [virt_exc_pkg::PID_W-1:0] part_i,
	input wire logic [virt_exc_pkg::ECH_W-1:0] chan_i,
	input wire logic wrong_i,
	// cpu state
	input wire logic [virt_exc_pkg::PID_W-1:0] cur_part_i,
	// request lines
	output logic gfast_o,
	output logic gord_o,
	output logic bfast_o,
	output logic bord_o,
	output logic [virt_exc_pkg::PID_W-1:0] part_o,
	output logic [virt_exc_pkg::FCH_W-1:0] fch_o,
	output logic [virt_exc_pkg::ECH_W-1:0] och_o
);
	logic here;

	// wrong_i sends a guest request although the partition differs
	assign here = (part_i == cur_part_i) | wrong_i;
	assign gfast_o = req_i & fast_i & here;
	assign gord_o = req_i & ~fast_i & here;
	assign bfast_o = req_i & fast_i & ~here;
	assign bord_o = req_i & ~fast_i & ~here;
	// idle fields show the inverse so stale values cannot pass
	assign part_o = req_i ? part_i : ~part_i;
	assign fch_o = req_i ? chan_i[3:0] : ~chan_i[3:0];
	assign och_o = req_i ? chan_i : ~chan_i;
endmodule

// ### test/testbench.sv
// self-checking bench for the virtualization exception cause coder
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("wrong value %s: expected %h seen %h", nm, e, g); end end
module testbench;
	import virt_exc_pkg::*;
	logic clk_i = 0;
	logic resetn_i = 0;
	logic gm = 0, etg = 0, nmi = 0, hf = 0, ho = 0, bse = 0, bre = 0, fbe = 0, fse = 0, fic = 0;
	logic mck = 0, hp = 1, gp = 1, tia = 0, rq = 0, rf = 0, wr = 0;
	logic [2:0] cur = 0, rp = 0;
	logic [10:0] rc = 0;
	logic [31:0] pc = 0, fpc = 0, hsw = 0, gsw = 0;
	access_e ak = ACC_FETCH;
	wire gfi, goi, bfi, boi, hack, gack, tk, hih, sth, ordl, term, miss;
	wire [2:0] ip;
	wire [3:0] fch;
	wire [10:0] och;
	wire [31:0] cause, hic, hpc, hst, hfc, gpc, gst, gfc;
	int fails = 0;
	int n_compared = 0;
	logic [31:0] lf = 32'h88ECA008;
	logic [31:0] e_hic = 0, e_hpc = 0, e_hst = 0, e_hfc = 0, e_gpc = 0, e_gst = 0, e_gfc = 0;

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	irq_ctrl_model ctrl (.req_i(rq), .fast_i(rf), .part_i(rp), .chan_i(rc), .wrong_i(wr),
		.cur_part_i(cur), .gfast_o(gfi), .gord_o(goi), .bfast_o(bfi), .bord_o(boi),
		.part_o(ip), .fch_o(fch), .och_o(och));

	virt_exception_cause_coder dut (.clk_i(clk_i), .resetn_i(resetn_i), .guest_mode_i(gm),
		.current_partition_id_i(cur), .pc_i(pc), .fetch_pc_i(fpc), .host_status_word_i(hsw),
		.guest_status_word_i(gsw), .exc_to_guest_i(etg), .host_nonmaskable_irq_i(nmi),
		.host_fast_irq_i(hf), .host_ordinary_irq_i(ho), .guest_fast_irq_i(gfi),
		.guest_ordinary_irq_i(goi), .background_fast_irq_i(bfi),
		.background_ordinary_irq_i(boi), .irq_partition_i(ip), .fast_channel_i(fch),
		.ordinary_channel_i(och), .bank_save_error_i(bse), .bank_restore_error_i(bre),
		.fetch_bus_error_i(fbe), .fetch_safety_error_i(fse), .fetch_from_icache_i(fic),
		.mpu_check_i(mck), .access_kind_i(ak), .host_permit_i(hp), .guest_permit_i(gp),
		.table_irq_access_i(tia), .host_irq_ack_o(hack), .guest_irq_ack_o(gack),
		.exception_taken_o(tk), .exception_cause_o(cause), .handle_in_host_o(hih),
		.switch_to_host_o(sth), .ordinary_level_o(ordl), .terminating_o(term),
		.icache_miss_o(miss), .host_irq_cause_reg_o(hic), .host_fatal_pc_save_o(hpc),
		.host_fatal_status_save_o(hst), .host_fatal_cause_o(hfc), .guest_fatal_pc_save_o(gpc),
		.guest_fatal_status_save_o(gst), .guest_fatal_cause_o(gfc));

	function automatic logic [31:0] nxt(input logic [31:0] v);
		for (int i = 0; i < 8; i++) begin
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		end
		return v;
	endfunction

	task automatic clr();
		{bse, bre, fbe, fse, fic, mck, nmi, hf, ho, rq, wr, tia} = '0;
		hp = 1;
		gp = 1;
	endtask

	task automatic rnd();
		lf = nxt(lf);
		pc = lf;
		fpc = ~lf;
		hsw = {lf[15:0], lf[31:16]};
		gsw = lf ^ 32'h5A5A5A5A;
		lf = nxt(lf);
		{cur, rp, rc, rf, gm, etg, hp, gp} = lf[21:0];
		ak = access_e'((lf[23:22] == 2'b11) ? 2'b01 : lf[23:22]);
		tia = lf[24];
		fic = lf[25];
		lf = nxt(lf);
		{bse, bre, fbe, fse, mck, nmi, hf, ho} = lf[7:0] & lf[23:16] & lf[31:24];
		rq = lf[8] | lf[9];
		wr = lf[10] & lf[11] & lf[12];
	endtask

	// reference model: predicts one cycle from the inputs now applied
	task automatic step();
		logic [31:0] fc, fp, bgc, ec;
		logic [7:0] ofs, mc;
		logic viol, pres, rt;
		int etk, ehh, esw, eol, etm, eha, ega;
		ofs = (ak == ACC_FETCH) ? 8'h00 : (ak == ACC_OPERAND) ? 8'h01 : 8'h05;
		viol = gm ? !(hp && gp) : !hp;
		mc = (!gm || (!hp && gp)) ? 8'h98 + ofs : 8'h90 + ofs;
		pres = rq && (rp == cur || wr);
		bgc = rf ? {13'h0000, rp, 8'hD8, 4'h0, rc[3:0]} : {13'h0000, rp, 4'hD, 1'b0, rc};
		fc = 0;
		fp = pc;
		etm = 0;
		if (bse) begin
			fc = 32'h0000001C;
			etm = 1;
		end else if (fbe) begin
			fc = 32'h00000011;
			fp = fpc;
			etm = 0;
		end else if (fse && !fic) begin
			fc = 32'h00000013;
			fp = fpc;
			etm = 0;
		end else if (bre) begin
			fc = 32'h0000001D;
			etm = 0;
		end else if (mck && viol) begin
			fc = {24'h000000, mc};
			etm = tia;
		end
		etk = 1;
		ec = 0;
		ehh = -1;
		esw = -1;
		eol = -1;
		eha = 0;
		ega = 0;
		if (fc != 0) begin
			rt = gm && etg;
			ehh = !rt;
			esw = gm && !rt;
			eol = 0;
			ec = fc;
			if (rt) begin
				e_gpc = fp;
				e_gst = gsw;
				e_gfc = fc;
			end else begin
				e_hpc = fp;
				e_hst = hsw;
				e_hfc = fc;
			end
		end else if (nmi || hf || ho) begin
			eha = 1;
			ehh = 1;
			esw = gm;
			eol = !nmi && !hf;
		end else if (gm && rq && !pres) begin
			ec = bgc;
			e_hic = bgc;
			ehh = 1;
			esw = 1;
			eol = 1;
		end else if (gm && rq && rp == cur) begin
			ega = 1;
			ehh = 0;
			esw = 0;
			eol = !rf;
		end else begin
			etk = 0;
			ehh = 0;
			esw = 0;
			eol = 0;
			etm = 0;
		end
		#1;
		`CHK("host ack", eha[0], hack)
		`CHK("guest ack", ega[0], gack)
		@(posedge clk_i);
		#1;
		`CHK("taken", etk[0], tk)
		`CHK("cause", ec, cause)
		`CHK("icache miss", fse && fic, miss)
		if (ehh >= 0) `CHK("in host", ehh[0], hih)
		if (esw >= 0) `CHK("switch", esw[0], sth)
		if (eol >= 0) `CHK("ordinary", eol[0], ordl)
		if (etm >= 0) `CHK("terminating", etm[0], term)
		`CHK("bg cause", e_hic, hic)
		`CHK("host pc", e_hpc, hpc)
		`CHK("host status", e_hst, hst)
		`CHK("host fcause", e_hfc, hfc)
		`CHK("guest pc", e_gpc, gpc)
		`CHK("guest status", e_gst, gst)
		`CHK("guest fcause", e_gfc, gfc)
	endtask

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#60000;
		fails++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		resetn_i = 1;
		clr();
		gm = 1;
		cur = 3'h2;
		rq = 1;
		rf = 1;
		rp = 3'h5;
		rc = 11'h003;
		step();
		rf = 0;
		rc = 11'h7FF;
		step();
		rq = 0;
		step();
		$display("test background done");
		// back-to-back system errors, both routings, and the cache case
		for (int i = 0; i < 10; i++) begin
			clr();
			gm = i[0];
			etg = 1;
			pc = 32'(32'h00000100 + i);
			fpc = 32'(32'h00000200 + i);
			hsw = 32'(i);
			gsw = ~32'(i);
			case (i / 2)
				0: bse = 1;
				1: bre = 1;
				2: fbe = 1;
				3: fse = 1;
				default: begin
					fse = 1;
					fic = 1;
				end
			endcase
			step();
		end
		$display("test system error done");
		for (int i = 0; i < 24; i++) begin
			clr();
			{etg, gp, hp, gm} = 4'(i);
			ak = access_e'(i / 8);
			tia = (i >= 16);
			mck = 1;
			pc = 32'(i);
			step();
		end
		$display("test protection done");
		for (int i = 0; i < 32; i++) begin
			clr();
			gm = i[0];
			cur = 3'h4;
			rq = 1;
			rp = i[1] ? 3'h4 : 3'h1;
			wr = i[2];
			rf = i[3];
			rc = 11'(i * 37);
			nmi = (i >= 24) && (i % 3 == 0);
			hf = (i >= 24) && (i % 3 == 1);
			ho = (i >= 24) && (i % 3 == 2);
			step();
		end
		$display("test interrupts done");
		repeat (3000) begin
			rnd();
			step();
		end
		$display("test random done");
		// mid-run reset clears every registered output at once
		resetn_i = 0;
		clr();
		#1;
		`CHK("reset taken", 1'b0, tk)
		`CHK("reset bg cause", 32'h0, hic)
		`CHK("reset host pc", 32'h0, hpc)
		`CHK("reset guest pc", 32'h0, gpc)
		e_hic = 0;
		e_hpc = 0;
		e_hst = 0;
		e_hfc = 0;
		e_gpc = 0;
		e_gst = 0;
		e_gfc = 0;
		repeat (2) @(posedge clk_i);
		#1;
		resetn_i = 1;
		gm = 1;
		cur = 3'h1;
		rq = 1;
		rf = 1;
		rp = 3'h6;
		rc = 11'h00A;
		step();
		$display("test reset done");
		end_sim();
	end
endmodule
